//--- pump_io_params.svh
// Constants for the pump discrete contact and relay block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef PUMP_IO_PARAMS_SVH
`define PUMP_IO_PARAMS_SVH

// Clock rate and timing figures
`define PIO_CLK_HZ 100000000
`define PIO_STATUS_DELAY_S 6
`define PIO_STATUS_DELAY_CYC (`PIO_STATUS_DELAY_S * `PIO_CLK_HZ)
`define PIO_DEBOUNCE_MS 10
`define PIO_DEBOUNCE_CYC (`PIO_DEBOUNCE_MS * (`PIO_CLK_HZ / 1000))

// Speed threshold in percent of rated speed
`define PIO_AT_SPEED_PCT 7'h50
`define PIO_FULL_PCT 7'h64

// Warning code window for the caution relay
`define PIO_WARN_CODE_LO 7'h56
`define PIO_WARN_CODE_HI 7'h5F

// Register byte offsets
`define PIO_REG_CTRL 4'h0
`define PIO_REG_WARN 4'h4
`define PIO_REG_RATED 4'h8
`define PIO_REG_STATUS 4'hC

// Control register fields
`define PIO_CTRL_FAILSAFE 0
`define PIO_CTRL_HALT_ANY 1
`define PIO_CTRL_OPMODE_LO 2
`define PIO_CTRL_OPMODE_HI 3
`define PIO_CTRL_ALTERNATE 4
`define PIO_CTRL_SW_RUN 5
`define PIO_CTRL_WIDTH 6
`define PIO_CTRL_RESET 6'h00
`define PIO_WARN_RESET 1'h1
`define PIO_RATED_RESET 16'h03E8

// Operating mode codes
`define PIO_OPMODE_LOCAL 2'h0
`define PIO_OPMODE_WIRED 2'h1
`define PIO_OPMODE_SERIAL 2'h2

// Relay indices
`define PIO_RLY_SPIN 0
`define PIO_RLY_ATSPEED 1
`define PIO_RLY_SPEEDUP 2
`define PIO_RLY_SLOWING 3
`define PIO_RLY_WIRED 4
`define PIO_RLY_FAULT 5
`define PIO_RLY_CAUTION 6
`define PIO_NUM_RELAYS 7
`define PIO_NUM_CONTACTS 4

// Contact indices
`define PIO_IN_START 0
`define PIO_IN_STOP 1
`define PIO_IN_RESET 2
`define PIO_IN_LOWSPEED 3

`endif

//--- pump_io_pkg.sv
// Types for the pump discrete contact and relay block.
// Widths follow the constants header.
package pump_io_pkg;

    // Pump run request state
    typedef enum logic [0:0] {
        RUN_STOPPED,
        RUN_ACTIVE
    } run_state_type;

    // Pump status inputs from the motor controller
    typedef struct packed {
        logic rotating;
        logic accelerating;
        logic decelerating;
        logic alarm_active;
        logic warning_valid;
        logic [6:0] warning_code;
        logic regen_active;
        logic [15:0] speed;
    } pump_status_type;

    // Relay contact pair outputs
    typedef struct packed {
        logic [6:0] make_closed;
        logic [6:0] break_closed;
    } relay_pair_type;

    // Contact filter state
    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic stable;
        logic [31:0] count;
    } filter_state_type;

    // Power-on validity timer state
    typedef struct packed {
        logic [31:0] count;
        logic done;
    } valid_timer_state_type;

    // Main block state
    typedef struct packed {
        run_state_type run_state;
        logic [5:0] ctrl;
        logic warn_en;
        logic [15:0] rated;
        logic [31:0] readdata;
        logic waitreq;
        logic start_prev;
        logic reset_prev;
        logic alarm_reset;
        logic run_cmd;
        logic low_speed;
        relay_pair_type relays;
    } io_state_type;

endpackage : pump_io_pkg

//--- contact_filter.sv
// Synchroniser and debouncer for one contact input.
// Assumes a bouncing level; output moves after DEBOUNCE_CYC stable cycles.
`timescale 1ns/1ns
`include "pump_io_params.svh"

module contact_filter #(
    parameter int unsigned DEBOUNCE_CYC = `PIO_DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Contact level, high while closed
    input wire logic contact_in,
    output logic clean_out
);

    pump_io_pkg::filter_state_type st_ff;
    pump_io_pkg::filter_state_type nxt_st;

    // Count while the synchronised level differs from the held level
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync_a = contact_in;
        nxt_st.sync_b = st_ff.sync_a; // First stage is read only here
        if (st_ff.sync_b == st_ff.stable) begin
            nxt_st.count = 32'h0;
        end else if (st_ff.count >= DEBOUNCE_CYC - 1) begin
            nxt_st.stable = st_ff.sync_b;
            nxt_st.count = 32'h0;
        end else begin
            nxt_st.count = st_ff.count + 32'h1;
        end
    end

    // State register
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign clean_out = st_ff.stable;

endmodule : contact_filter

//--- valid_timer.sv
// Power-on timer marking when status outputs are valid.
// Assumes reset_n_in is released when power comes up.
`timescale 1ns/1ns
`include "pump_io_params.svh"

module valid_timer #(
    parameter int unsigned DELAY_CYC = `PIO_STATUS_DELAY_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // High once the settle time has run out
    output logic valid_out
);

    pump_io_pkg::valid_timer_state_type st_ff;
    pump_io_pkg::valid_timer_state_type nxt_st;

    // Count once after reset, then hold
    always_comb begin
        nxt_st = st_ff;
        if (!st_ff.done) begin
            if (st_ff.count >= DELAY_CYC - 1) begin
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.count = st_ff.count + 32'h1;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign valid_out = st_ff.done;

endmodule : valid_timer

//--- pump_discrete_io_control.sv
// Contact inputs and indicator relays of the pump controller.
// Assumes Avalon-MM access and contacts high while closed;
// motor status is synchronous to mclk_in.
//
// What this block does
// - Momentary wiring: start contact closure starts the pump.
// - Open stop contact stops the pump; stop is a closed loop.
// - Alternate wiring: run while stop loop closed, stop while open.
// - Start and stop together: stop wins.
// - One alarm reset per reset contact closure.
// - Reduced-speed contact selects the variable speed.
// - Spinning relay on while the rotor turns.
// - At-speed relay on above 80 percent of rated speed.
// - Speeding-up relay on while accelerating.
// - Slowing relay on while decelerating.
// - Hardwired-control relay on when contact control is available.
// - Fault relay follows the alarm, selected polarity.
// - Caution relay follows the warning, selected polarity.
// - Status outputs invalid for 6 seconds after power-up.
// - Fail-safe mode: make closed when healthy, else break.
// - Legacy mode drops hardwired indicator in regenerative control.
// - Fail-safe mode keeps hardwired indicator on when enabled.
// - Wired-only stop: acts only in hardwired mode.
// - Any-mode stop: open stop wins under serial control.
// - Register settings select stop and relay behaviour.
// - Caution only for warning codes 86 through 95 when enabled.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`include "pump_io_params.svh"

module pump_discrete_io_control #(
    parameter int unsigned STATUS_DELAY_CYC = `PIO_STATUS_DELAY_CYC,
    parameter int unsigned DEBOUNCE_CYC = `PIO_DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Contact inputs, high while shorted to input ground
    input wire logic start_contact_in,
    input wire logic stop_contact_in,
    input wire logic reset_contact_in,
    input wire logic low_speed_contact_in,
    // Status from the motor controller
    input wire pump_io_pkg::pump_status_type pump_status_in,
    // Requests to the motor controller
    output logic run_cmd_out,
    output logic low_speed_out,
    output logic alarm_reset_out,
    // Indicator relays
    output pump_io_pkg::relay_pair_type relays_out,
    output logic status_valid_out
);

    pump_io_pkg::io_state_type st_ff;
    pump_io_pkg::io_state_type nxt_st;
    logic [`PIO_NUM_CONTACTS-1:0] raw_contacts;
    logic [`PIO_NUM_CONTACTS-1:0] clean;
    logic valid;
    logic valid_ff;

    assign raw_contacts[`PIO_IN_START] = start_contact_in;
    assign raw_contacts[`PIO_IN_STOP] = stop_contact_in;
    assign raw_contacts[`PIO_IN_RESET] = reset_contact_in;
    assign raw_contacts[`PIO_IN_LOWSPEED] = low_speed_contact_in;

    // One filter per contact so bounce never reaches the run logic
    for (genvar i = 0; i < `PIO_NUM_CONTACTS; i++) begin : g_filter
        contact_filter #(
            .DEBOUNCE_CYC(DEBOUNCE_CYC)
        ) u_filter (
            .mclk_in(mclk_in),
            .reset_n_in(reset_n_in),
            .contact_in(raw_contacts[i]),
            .clean_out(clean[i])
        );
    end

    // Settle timer after power-up
    valid_timer #(
        .DELAY_CYC(STATUS_DELAY_CYC)
    ) u_valid (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .valid_out(valid)
    );

    // Re-time valid so the output comes from a flop
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= valid;
        end
    end

    // Decoded settings
    logic failsafe;
    logic halt_any;
    logic [1:0] opmode;
    logic wired_mode;
    logic serial_mode;
    logic alternate;
    logic sw_run;

    assign failsafe = st_ff.ctrl[`PIO_CTRL_FAILSAFE];
    assign halt_any = st_ff.ctrl[`PIO_CTRL_HALT_ANY];
    assign opmode = st_ff.ctrl[`PIO_CTRL_OPMODE_HI:`PIO_CTRL_OPMODE_LO];
    assign wired_mode = (opmode == `PIO_OPMODE_WIRED);
    assign serial_mode = (opmode == `PIO_OPMODE_SERIAL);
    assign alternate = st_ff.ctrl[`PIO_CTRL_ALTERNATE];
    assign sw_run = st_ff.ctrl[`PIO_CTRL_SW_RUN];

    // Contact events
    logic start_edge;
    logic reset_edge;
    logic stop_open;
    logic halt_now;

    assign start_edge = clean[`PIO_IN_START] & ~st_ff.start_prev;
    assign reset_edge = clean[`PIO_IN_RESET] & ~st_ff.reset_prev;
    assign stop_open = ~clean[`PIO_IN_STOP];
    // Wired-only setting ignores the loop outside hardwired mode
    assign halt_now = stop_open & (wired_mode | halt_any);

    // Speed comparison scaled to percent without a divider
    logic [23:0] speed_scaled;
    logic [23:0] rated_scaled;
    logic at_speed;

    assign speed_scaled = pump_status_in.speed * `PIO_FULL_PCT;
    assign rated_scaled = st_ff.rated * `PIO_AT_SPEED_PCT;
    assign at_speed = (speed_scaled > rated_scaled);

    // Warning window for the caution relay
    logic caution_cond;
    logic wired_ind;

    assign caution_cond = st_ff.warn_en & pump_status_in.warning_valid
        & (pump_status_in.warning_code >= `PIO_WARN_CODE_LO)
        & (pump_status_in.warning_code <= `PIO_WARN_CODE_HI);
    // Legacy mode hides it in regenerative ride-through
    assign wired_ind = wired_mode
        & (failsafe | ~pump_status_in.regen_active);

    // Condition per relay, before polarity is applied
    logic [`PIO_NUM_RELAYS-1:0] cond;

    always_comb begin
        cond = '0;
        cond[`PIO_RLY_SPIN] = pump_status_in.rotating;
        cond[`PIO_RLY_ATSPEED] = at_speed;
        cond[`PIO_RLY_SPEEDUP] = pump_status_in.accelerating;
        cond[`PIO_RLY_SLOWING] = pump_status_in.decelerating;
        cond[`PIO_RLY_WIRED] = wired_ind;
        cond[`PIO_RLY_FAULT] = pump_status_in.alarm_active;
        cond[`PIO_RLY_CAUTION] = caution_cond;
    end

    // Register read mux
    logic [31:0] rd_value;

    always_comb begin
        rd_value = 32'h0;
        unique case (avs_address_in)
            `PIO_REG_CTRL: begin
                rd_value[`PIO_CTRL_WIDTH-1:0] = st_ff.ctrl;
            end
            `PIO_REG_WARN: begin
                rd_value[0] = st_ff.warn_en;
            end
            `PIO_REG_RATED: begin
                rd_value[15:0] = st_ff.rated;
            end
            `PIO_REG_STATUS: begin
                rd_value[3:0] = clean;
                rd_value[4] = (st_ff.run_state == pump_io_pkg::RUN_ACTIVE);
                rd_value[5] = st_ff.low_speed;
                rd_value[6] = valid_ff;
                rd_value[7] = halt_now;
                rd_value[14:8] = cond;
            end
            default: begin
                rd_value = 32'h0; // Unmapped offsets read as zero
            end
        endcase
    end

    // Next-state logic
    logic bus_req;
    logic bus_done;

    assign bus_req = avs_read_in | avs_write_in;
    assign bus_done = bus_req & ~st_ff.waitreq;

    always_comb begin
        nxt_st = st_ff;

        // One wait cycle per access
        nxt_st.waitreq = ~(bus_req & st_ff.waitreq);
        if (bus_req & st_ff.waitreq) begin
            nxt_st.readdata = rd_value;
        end
        // Settings select stop scope and relay polarity
        if (avs_write_in & bus_done) begin
            unique case (avs_address_in)
                `PIO_REG_CTRL: begin
                    nxt_st.ctrl = avs_writedata_in[`PIO_CTRL_WIDTH-1:0];
                end
                `PIO_REG_WARN: begin
                    nxt_st.warn_en = avs_writedata_in[0];
                end
                `PIO_REG_RATED: begin
                    nxt_st.rated = avs_writedata_in[15:0];
                end
                default: begin
                    nxt_st.rated = st_ff.rated; // Read-only or unmapped
                end
            endcase
        end

        // Edge memories for momentary contacts
        nxt_st.start_prev = clean[`PIO_IN_START];
        nxt_st.reset_prev = clean[`PIO_IN_RESET];
        nxt_st.alarm_reset = reset_edge & wired_mode;

        // Run request; a stop overrides any start
        unique case (st_ff.run_state)
            pump_io_pkg::RUN_STOPPED: begin
                if (halt_now) begin
                    nxt_st.run_state = pump_io_pkg::RUN_STOPPED;
                end else if (wired_mode & alternate) begin
                    if (clean[`PIO_IN_STOP]) begin
                        nxt_st.run_state = pump_io_pkg::RUN_ACTIVE;
                    end
                end else if (wired_mode & start_edge) begin
                    nxt_st.run_state = pump_io_pkg::RUN_ACTIVE;
                end else if (serial_mode & sw_run) begin
                    nxt_st.run_state = pump_io_pkg::RUN_ACTIVE;
                end
            end
            pump_io_pkg::RUN_ACTIVE: begin
                if (halt_now) begin
                    nxt_st.run_state = pump_io_pkg::RUN_STOPPED;
                end else if (serial_mode & ~sw_run) begin
                    nxt_st.run_state = pump_io_pkg::RUN_STOPPED;
                end else if (opmode == `PIO_OPMODE_LOCAL) begin
                    nxt_st.run_state = pump_io_pkg::RUN_STOPPED;
                end
            end
        endcase
        nxt_st.run_cmd = (nxt_st.run_state == pump_io_pkg::RUN_ACTIVE);

        // Reduced speed follows its contact in hardwired mode
        nxt_st.low_speed = wired_mode & clean[`PIO_IN_LOWSPEED];

        // Relays released until status is valid
        for (int r = 0; r < `PIO_NUM_RELAYS; r++) begin
            if (!valid_ff) begin
                nxt_st.relays.make_closed[r] = 1'b0;
            end else if ((r == `PIO_RLY_FAULT || r == `PIO_RLY_CAUTION)
                    && failsafe) begin
                nxt_st.relays.make_closed[r] = ~cond[r];
            end else begin
                nxt_st.relays.make_closed[r] = cond[r];
            end
            nxt_st.relays.break_closed[r] = ~nxt_st.relays.make_closed[r];
        end
    end

    // State register
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_ff.run_state <= pump_io_pkg::RUN_STOPPED;
            st_ff.ctrl <= `PIO_CTRL_RESET;
            st_ff.warn_en <= `PIO_WARN_RESET;
            st_ff.rated <= `PIO_RATED_RESET;
            st_ff.readdata <= 32'h0;
            st_ff.waitreq <= 1'b1;
            st_ff.start_prev <= 1'b0;
            st_ff.reset_prev <= 1'b0;
            st_ff.alarm_reset <= 1'b0;
            st_ff.run_cmd <= 1'b0;
            st_ff.low_speed <= 1'b0;
            st_ff.relays.make_closed <= 7'h00;
            st_ff.relays.break_closed <= 7'h7F;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign avs_readdata_out = st_ff.readdata;
    assign avs_waitrequest_out = st_ff.waitreq;
    assign run_cmd_out = st_ff.run_cmd;
    assign low_speed_out = st_ff.low_speed;
    assign alarm_reset_out = st_ff.alarm_reset;
    assign relays_out = st_ff.relays;
    assign status_valid_out = valid_ff;

endmodule : pump_discrete_io_control

//--- pump_io_assertions.sv
// Checker for the pump contact block: bus pacing and relays.
// Sees only top ports; settings shadowed from completed writes.
`timescale 1ns/1ns

module pump_io_assertions #(
    parameter int unsigned STATUS_DELAY_CYC = 50,
    parameter int unsigned DEBOUNCE_CYC = 4
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Register bus
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    // Contacts and status
    input wire logic stop_contact_in,
    input wire pump_io_pkg::pump_status_type pump_status_in,
    // Outputs
    input wire logic run_cmd_out,
    input wire logic alarm_reset_out,
    input wire pump_io_pkg::relay_pair_type relays_out,
    input wire logic status_valid_out
);
    logic [5:0] ctrl_ff;
    logic [31:0] since_ff;
    logic [7:0] open_ff;
    // Shadow settings from completed writes
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_ff <= 6'h00;
            since_ff <= 32'h0;
            open_ff <= 8'h00;
        end else begin
            if (avs_write_in && !avs_waitrequest_out
                && avs_address_in == 4'h0) begin
                ctrl_ff <= avs_writedata_in[5:0];
            end
            if (!status_valid_out) begin
                since_ff <= since_ff + 32'h1;
            end
            if (stop_contact_in) begin
                open_ff <= 8'h00;
            end else if (open_ff != 8'hFF) begin
                open_ff <= open_ff + 8'h01;
            end
        end
    end
    // Expected relay conditions
    wire fs_w = ctrl_ff[0];
    wire wired_w = ctrl_ff[3:2] == 2'h1;
    wire warn_w = pump_status_in.warning_valid
        && pump_status_in.warning_code inside {[7'h56:7'h5F]};
    wire hw_ind_w = wired_w && (fs_w || !pump_status_in.regen_active);
    wire halt_w = (wired_w || ctrl_ff[1])
        && open_ff >= 8'(DEBOUNCE_CYC + 6);

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_req_seen;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_answer;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    a_bus_one_wait: assert property (s_req_seen |=> s_answer)
        else $error("bus wait wrong");
    a_relay_pairs: assert property (
        relays_out.make_closed == ~relays_out.break_closed)
        else $error("relay pair wrong");
    a_released_early: assert property (
        !status_valid_out |-> relays_out.make_closed == 7'h00)
        else $error("relay closed early");
    a_valid_delay: assert property ($rose(status_valid_out) |->
        since_ff >= STATUS_DELAY_CYC && since_ff <= STATUS_DELAY_CYC + 2)
        else $error("valid timing wrong");
    a_motion_relays: assert property (status_valid_out |=>
        relays_out.make_closed[0] == $past(pump_status_in.rotating)
        && relays_out.make_closed[2] == $past(pump_status_in.accelerating)
        && relays_out.make_closed[3] == $past(pump_status_in.decelerating))
        else $error("motion relay wrong");
    a_fault_polarity: assert property (status_valid_out |=>
        relays_out.make_closed[5]
        == $past(pump_status_in.alarm_active ^ fs_w))
        else $error("fault relay wrong");
    a_caution_polarity: assert property (
        status_valid_out && (warn_w || !pump_status_in.warning_valid)
        |=> relays_out.make_closed[6] == $past(warn_w ^ fs_w))
        else $error("caution relay wrong");
    a_wired_indicator: assert property (status_valid_out |=>
        relays_out.make_closed[4] == $past(hw_ind_w))
        else $error("hardwired indicator wrong");
    a_reset_pulse: assert property (
        alarm_reset_out |-> wired_w ##1 !alarm_reset_out)
        else $error("alarm reset pulse wrong");
    a_stop_wins: assert property (halt_w |-> !run_cmd_out)
        else $error("stop did not win");
endmodule : pump_io_assertions

bind pump_discrete_io_control pump_io_assertions #(
    .STATUS_DELAY_CYC(STATUS_DELAY_CYC),
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
) u_chk (.*);

//--- pump_switch_panel.sv
// Switch panel model: four dry contacts that chatter on change.
// Assumes targets are set just after a rising edge.
`timescale 1ns/1ns

module pump_switch_panel (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Target levels, high = contact closed
    input wire logic [3:0] want_in,
    // Contact lines towards the block
    output logic [3:0] contact_out
);
    logic [3:0] lvl_ff;
    logic [3:0] jit_ff;
    logic [1:0] cnt_ff [4];
    // A change chatters three cycles, shorter than the debounce window
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lvl_ff <= 4'h0;
            jit_ff <= 4'h5;
            for (int i = 0; i < 4; i++) cnt_ff[i] <= 2'h0;
        end else begin
            jit_ff <= ~jit_ff;
            for (int i = 0; i < 4; i++) begin
                if (want_in[i] == lvl_ff[i]) begin
                    cnt_ff[i] <= 2'h0;
                end else if (cnt_ff[i] == 2'h3) begin
                    lvl_ff[i] <= want_in[i];
                    cnt_ff[i] <= 2'h0;
                end else begin
                    cnt_ff[i] <= cnt_ff[i] + 2'h1;
                end
            end
        end
    end
    // While chattering the line flips every cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            contact_out[i] = (cnt_ff[i] != 2'h0) ? jit_ff[i] : lvl_ff[i];
        end
    end
endmodule : pump_switch_panel

//--- tb_pump_discrete_io_control.sv
// Self-checking bench for the pump contact and relay block.
// Short settle and debounce counts; the panel model bounces.
`timescale 1ns/1ns

module tb_pump_discrete_io_control;
    localparam int SETTLE = 24;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0, wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [3:0] want = 4'h0;
    logic [3:0] contact;
    pump_io_pkg::pump_status_type st = '0;
    logic waitreq, run, low, arst, valid;
    pump_io_pkg::relay_pair_type rly;
    int err_total = 0;
    int total_checks = 0;
    int pulses = 0;
    logic [31:0] exp_q [$];

    always #5 mclk_in = ~mclk_in;

    pump_switch_panel panel (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .want_in(want), .contact_out(contact));
    pump_discrete_io_control #(.STATUS_DELAY_CYC(50), .DEBOUNCE_CYC(4)) dut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .start_contact_in(contact[0]),
        .stop_contact_in(contact[1]), .reset_contact_in(contact[2]),
        .low_speed_contact_in(contact[3]), .pump_status_in(st),
        .run_cmd_out(run), .low_speed_out(low), .alarm_reset_out(arst),
        .relays_out(rly), .status_valid_out(valid));

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc
    task automatic fail(input string msg);
        err_total++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : fail
    task automatic chk(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask : chk
    task automatic chkv(input logic [31:0] got, exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask : chkv
    // Request stands until waitrequest is seen low; watchdog ends a hang
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge mclk_in);
        while (waitreq !== 1'b0) @(posedge mclk_in);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdx(input logic [3:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rdx
    task automatic set(input int i, input logic v);
        want[i] <= v;
        cyc(SETTLE);
    endtask : set
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // Read data matched against the oldest note
    always @(posedge mclk_in) begin
        if (rd && waitreq === 1'b0) begin
            total_checks++;
            if (exp_q.size() == 0) fail("unexpected read");
            else if (rdata !== exp_q.pop_front()) fail("read");
        end
        if (arst === 1'b1) pulses++;
    end

    // Watchdog well above the few hundred cycles needed
    initial begin
        cyc(8000);
        fail("timeout");
        test_done();
    end

    initial begin
        void'($urandom(60719));
        cyc(5);
        chk(run, 1'b0, "run in reset");
        chk(valid, 1'b0, "valid in reset");
        chkv({25'h0, rly.break_closed}, 32'h7F, "in reset");
        reset_n_in <= 1'b1;
        rdx(4'h0, 32'h0);
        rdx(4'h4, 32'h1);
        rdx(4'h8, 32'h3E8);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        rdx(4'h2, 32'h0);
        bus(1'b1, 4'h0, 32'h4);
        rdx(4'h0, 32'h4);
        set(1, 1'b1);
        while (valid !== 1'b1) cyc(1);
        cyc(2);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            st.rotating <= k[0];
            st.accelerating <= k[1];
            st.decelerating <= k[2];
            st.speed <= k[0] ? 16'(900 + $urandom_range(99))
                             : 16'($urandom_range(700));
            cyc(2);
            chkv({28'h0, rly.make_closed[3:0]},
                 {28'h0, k[2], k[1], k[0], k[0]}, "motion");
        end
        st.alarm_active <= 1'b1;
        st.warning_valid <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            st.warning_code <= k[0] ? 7'h5F : 7'h56;
            cyc(2);
            chk(rly.make_closed[6], 1'b1, "caution legacy");
            chk(rly.break_closed[5], 1'b0, "fault legacy");
        end
        $display("test relays done");
        set(0, 1'b1);
        set(0, 1'b0);
        chk(run, 1'b1, "momentary start");
        set(3, 1'b1);
        chk(low, 1'b1, "reduced speed");
        set(3, 1'b0);
        set(0, 1'b1);
        set(1, 1'b0);
        chk(run, 1'b0, "stop beats start");
        set(0, 1'b0);
        set(1, 1'b1);
        set(2, 1'b1);
        set(2, 1'b0);
        set(2, 1'b1);
        set(2, 1'b0);
        chkv(32'(pulses), 32'h2, "reset pulses");
        $display("test contacts done");
        st.regen_active <= 1'b1;
        cyc(2);
        chk(rly.make_closed[4], 1'b0, "legacy regen");
        bus(1'b1, 4'h0, 32'h5);
        cyc(2);
        chk(rly.make_closed[4], 1'b1, "failsafe wired");
        chk(rly.make_closed[5], 1'b0, "failsafe alarm");
        st.alarm_active <= 1'b0;
        cyc(2);
        chk(rly.make_closed[5], 1'b1, "failsafe ok");
        bus(1'b1, 4'h0, 32'h2B);
        cyc(3);
        chk(run, 1'b1, "serial run");
        set(1, 1'b0);
        chk(run, 1'b0, "any-mode stop");
        bus(1'b1, 4'h0, 32'h29);
        cyc(3);
        chk(run, 1'b1, "wired-only stop");
        set(1, 1'b1);
        // Alternate wiring: panel drives only the stop loop
        bus(1'b1, 4'h0, 32'h14);
        cyc(3);
        chk(run, 1'b1, "alt closed");
        set(1, 1'b0);
        chk(run, 1'b0, "alt open");
        set(1, 1'b1);
        chk(run, 1'b1, "alt again");
        $display("test modes done");
        test_done();
    end
endmodule : tb_pump_discrete_io_control
